// ===== hw/uec_top.sv
/*
  Endpoint control and status logic of a full-speed device controller:
  eight endpoint registers, token routing, reply selection and the
  completion bookkeeping that follows a transaction.
  Assumes the serial engine presents a token as a one-cycle pulse that
  already passed device address filtering, and later reports the end of
  any accepted transaction with one pulse. Word register access.
*/
// Notes on behaviour
// - Successful OUT/SETUP sets receive done flag
// - Receive done: write zero clears, one keeps
// - Receive toggle tracks expected DATA0/DATA1
// - Receive state: ignore, stall, NAK, accept
// - Setup indicator tells OUT from SETUP
// - Transfer kind decode; extend for bulk/control
// - Bulk with extend runs double-buffered
// - Control extend: nonzero SETUP length stalls
// - Successful IN sets transmit done flag
// - Transmit done: write zero clears, one keeps
// - Transmit toggle selects DATA0/DATA1 for IN
// - Transmit state: ignore, stall, NAK, send
// - Double OUT: transmit toggle selects buffer
// - Double IN: receive toggle selects buffer
`timescale 1ns/1ps
`default_nettype none
module uec_top #(
  parameter int NUM_EP = uec_pkg::NUM_EP
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  // Register access
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [uec_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic [31:0]                      reg_rdata,
  output logic                             reg_rvalid,
  // Serial engine side
  input  wire logic                        tok_valid,
  input  wire uec_pkg::uec_token_s         tok,
  input  wire logic                        xact_done,
  input  wire logic                        xact_ok,
  output logic                             ans_valid,
  output uec_pkg::uec_answer_s             ans,
  output logic                             busy
);
  // Endpoint register values and per-endpoint controls
  logic [uec_pkg::REG_W-1:0]         ep_val [NUM_EP];
  logic [NUM_EP*uec_pkg::EPN_W-1:0]  ep_nums;   // Number fields, packed
  logic [NUM_EP-1:0]                 ep_wr;     // Write strobes
  uec_pkg::uec_evt_s                 ep_evt [NUM_EP];

  // Register decode
  logic                              addr_hit;  // Mapped word address
  logic [uec_pkg::IDX_W-1:0]         addr_idx;  // Addressed endpoint
  logic [31:0]                       rdata_r;   // Read data
  logic                              rvalid_r;  // Read answer pulse

  // Token routing and reply selection
  logic                              m_hit;     // Some register matches
  logic [uec_pkg::IDX_W-1:0]         m_idx;     // Matching register
  logic [uec_pkg::REG_W-1:0]         sel;       // Matching register value
  uec_pkg::uec_hs_e                  hs_w;      // Relevant handshake state
  uec_pkg::uec_kind_e                kind_w;    // Transfer kind
  logic                              ext_w;     // Extend function bit
  logic                              dbl_w;     // Double-buffered endpoint
  uec_pkg::uec_answer_s              ans_w;     // Answer being formed
  logic                              take_w;    // Token starts a transaction

  // Transaction tracking
  uec_pkg::uec_state_e               state_r;
  uec_pkg::uec_state_e               state_nxt;
  uec_pkg::uec_answer_s              ans_r;     // Answer held for engine
  logic                              ans_valid_r;
  uec_pkg::uec_tok_e                 cur_kind_r; // Token kind in flight
  logic                              cur_iso_r; // Isochronous in flight

  // Address decode: aligned words inside the endpoint span
  always_comb begin
    addr_hit = (reg_addr[uec_pkg::IDX_LO-1:0] == '0) &&
               (reg_addr >= uec_pkg::EP_BASE) &&
               (reg_addr < (uec_pkg::EP_BASE + uec_pkg::EP_SPAN));
    addr_idx = reg_addr[uec_pkg::IDX_LO +: uec_pkg::IDX_W];
  end

  // Endpoint registers, one per endpoint
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      // Write strobe for this register
      assign ep_wr[g] = reg_wr && addr_hit &&
                        (addr_idx == uec_pkg::IDX_W'(g));
      // Number field feeds the matcher
      assign ep_nums[g*uec_pkg::EPN_W +: uec_pkg::EPN_W] =
        ep_val[g][uec_pkg::EPN_LO +: uec_pkg::EPN_W];
      // Completion events for the endpoint in flight
      always_comb begin
        ep_evt[g] = '0;
        if ((state_r == uec_pkg::ST_BUSY) && xact_done && xact_ok &&
            (ans_r.ep_idx == uec_pkg::IDX_W'(g))) begin
          if (cur_kind_r == uec_pkg::TOK_IN) begin
            ep_evt[g].tx_done = 1'b1;
            ep_evt[g].tx_flip = !cur_iso_r;
          end else begin
            ep_evt[g].rx_done = 1'b1;
            ep_evt[g].setup   = (cur_kind_r == uec_pkg::TOK_SETUP);
            ep_evt[g].rx_flip = !cur_iso_r;
          end
        end
      end
      uec_ep_reg u_reg (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .wr_en   (ep_wr[g]),
        .wdata   (reg_wdata[uec_pkg::REG_W-1:0]),
        .evt     (ep_evt[g]),
        .value   (ep_val[g])
      );
    end
  endgenerate

  // Read path: one cycle behind the strobe, unmapped reads as zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_r  <= uec_pkg::RD_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        if (addr_hit) begin
          rdata_r <= {16'h0000, ep_val[addr_idx]};
        end else begin
          rdata_r <= uec_pkg::RD_ZERO;
        end
      end
    end
  end

  // Find the register whose number field equals the token's
  uec_ep_match #(
    .NUM (NUM_EP)
  ) u_match (
    .ep_nums (ep_nums),
    .tok_ep  (tok.ep),
    .hit     (m_hit),
    .idx     (m_idx)
  );

  // Reply for the routed token
  always_comb begin
    sel    = ep_val[m_idx];
    kind_w = uec_pkg::uec_kind_e'(sel[uec_pkg::KIND_LO +: 2]);
    ext_w  = sel[uec_pkg::EXT_B];
    // Extend only means double buffering on bulk endpoints
    dbl_w  = (kind_w == uec_pkg::KIND_BULK) && ext_w;
    if (tok.kind == uec_pkg::TOK_IN) begin
      hs_w = uec_pkg::uec_hs_e'(sel[uec_pkg::TX_HS_LO +: 2]);
    end else begin
      hs_w = uec_pkg::uec_hs_e'(sel[uec_pkg::RX_HS_LO +: 2]);
    end
    ans_w        = '0;
    ans_w.ep_idx = m_idx;
    ans_w.dbl_buf = dbl_w;
    // Handshake state picks the reply
    case (hs_w)
      uec_pkg::HS_DISABLED: ans_w.reply = uec_pkg::REPLY_IGNORE;
      uec_pkg::HS_STALL:    ans_w.reply = uec_pkg::REPLY_STALL;
      uec_pkg::HS_NAK:      ans_w.reply = uec_pkg::REPLY_NAK;
      uec_pkg::HS_VALID: begin
        if (tok.kind == uec_pkg::TOK_IN) begin
          ans_w.reply = uec_pkg::REPLY_SEND;
        end else begin
          ans_w.reply = uec_pkg::REPLY_ACCEPT;
        end
      end
      default:              ans_w.reply = uec_pkg::REPLY_IGNORE;
    endcase
    // Control endpoint with extend refuses a SETUP carrying data
    if ((tok.kind == uec_pkg::TOK_SETUP) && (kind_w == uec_pkg::KIND_CTRL) &&
        ext_w && tok.setup_len_nz && (hs_w != uec_pkg::HS_DISABLED)) begin
      ans_w.reply = uec_pkg::REPLY_STALL;
    end
    // Data toggle and buffer selection per direction
    if (tok.kind == uec_pkg::TOK_IN) begin
      ans_w.toggle  = sel[uec_pkg::TX_TOG_B];
      ans_w.buf_sel = dbl_w && !sel[uec_pkg::RX_TOG_B];
    end else begin
      ans_w.toggle  = sel[uec_pkg::RX_TOG_B];
      ans_w.buf_sel = dbl_w && !sel[uec_pkg::TX_TOG_B];
    end
    // Unmatched endpoint number gets no reply at all
    if (!m_hit) begin
      ans_w.reply = uec_pkg::REPLY_IGNORE;
    end
  end

  // Only data-moving replies open a transaction
  assign take_w = tok_valid && (state_r == uec_pkg::ST_IDLE) &&
                  ((ans_w.reply == uec_pkg::REPLY_ACCEPT) ||
                   (ans_w.reply == uec_pkg::REPLY_SEND));

  // Tracker next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      uec_pkg::ST_IDLE: begin
        if (take_w) begin
          state_nxt = uec_pkg::ST_BUSY;
        end
      end
      uec_pkg::ST_BUSY: begin
        if (xact_done) begin
          state_nxt = uec_pkg::ST_IDLE;
        end
      end
      default: state_nxt = uec_pkg::ST_IDLE;
    endcase
  end

  // Tracker state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= uec_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Answer register: loaded for every token that arrives while idle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ans_r       <= '0;
      ans_valid_r <= 1'b0;
    end else begin
      ans_valid_r <= tok_valid && (state_r == uec_pkg::ST_IDLE);
      if (tok_valid && (state_r == uec_pkg::ST_IDLE)) begin
        ans_r <= ans_w;
      end
    end
  end

  // Kind of the transaction in flight
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cur_kind_r <= uec_pkg::TOK_OUT;
      cur_iso_r  <= 1'b0;
    end else if (take_w) begin
      cur_kind_r <= tok.kind;
      cur_iso_r  <= (kind_w == uec_pkg::KIND_ISO);
    end
  end

  // Outputs
  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign ans        = ans_r;
  assign ans_valid  = ans_valid_r;
  assign busy       = (state_r == uec_pkg::ST_BUSY);
endmodule : uec_top
`default_nettype wire

// ===== hw/uec_pkg.sv
/*
  Shared constants and types of the endpoint control and status block.
  Assumes a 16-bit endpoint register per endpoint, word-spaced.
*/
package uec_pkg;
  // Geometry
  localparam int          NUM_EP      = 8;     // Endpoint registers
  localparam int          IDX_W       = 3;     // Index width
  localparam int          EPN_W       = 4;     // Endpoint number width
  localparam int          ADDR_W      = 8;     // Register byte address
  localparam int          REG_W       = 16;    // Register width
  localparam logic [7:0]  EP_BASE     = 8'h00; // First register
  localparam logic [7:0]  EP_SPAN     = 8'h20; // Eight words
  localparam int          IDX_LO      = 2;     // Word index bit
  // Field positions
  localparam int RX_DONE_B = 15;
  localparam int RX_TOG_B  = 14;
  localparam int RX_HS_LO  = 12;
  localparam int SETUP_B   = 11;
  localparam int KIND_LO   = 9;
  localparam int EXT_B     = 8;
  localparam int TX_DONE_B = 7;
  localparam int TX_TOG_B  = 6;
  localparam int TX_HS_LO  = 4;
  localparam int EPN_LO    = 0;
  // Access classes
  localparam logic [15:0] W0C_MASK  = 16'h8080; // Write zero clears
  localparam logic [15:0] TOG_MASK  = 16'h7070; // Write one inverts
  localparam logic [15:0] RW_MASK   = 16'h070f; // Plain read/write
  localparam logic [15:0] EP_RESET  = 16'h0000; // Reset value
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // Handshake state of a direction
  typedef enum logic [1:0] {
    HS_DISABLED = 2'b00,
    HS_STALL    = 2'b01,
    HS_NAK      = 2'b10,
    HS_VALID    = 2'b11
  } uec_hs_e;

  // Transfer kind
  typedef enum logic [1:0] {
    KIND_BULK = 2'b00,
    KIND_CTRL = 2'b01,
    KIND_ISO  = 2'b10,
    KIND_INTR = 2'b11
  } uec_kind_e;

  // Token kind from the serial engine
  typedef enum logic [1:0] {
    TOK_OUT   = 2'b00,
    TOK_IN    = 2'b01,
    TOK_SETUP = 2'b10
  } uec_tok_e;

  // Reply chosen for a token
  typedef enum logic [2:0] {
    REPLY_IGNORE = 3'b000,
    REPLY_STALL  = 3'b001,
    REPLY_NAK    = 3'b010,
    REPLY_ACCEPT = 3'b011,
    REPLY_SEND   = 3'b100
  } uec_reply_e;

  // Transaction tracker states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } uec_state_e;

  // Token presented by the serial engine
  typedef struct packed {
    uec_tok_e          kind;
    logic [EPN_W-1:0]  ep;
    logic              setup_len_nz;
  } uec_token_s;

  // Answer to the serial engine
  typedef struct packed {
    uec_reply_e        reply;
    logic              toggle;
    logic              dbl_buf;
    logic              buf_sel;
    logic [IDX_W-1:0]  ep_idx;
  } uec_answer_s;

  // Hardware events applied to one endpoint register
  typedef struct packed {
    logic rx_done;
    logic setup;
    logic tx_done;
    logic rx_flip;
    logic tx_flip;
  } uec_evt_s;
endpackage : uec_pkg

// ===== hw/uec_ep_match.sv
/*
  Endpoint number matcher: finds the register holding a token's number.
  Assumes the token is already known to carry this device's address.
*/
`timescale 1ns/1ps
`default_nettype none
module uec_ep_match #(
  parameter int NUM = uec_pkg::NUM_EP
) (
  input  wire logic [NUM*uec_pkg::EPN_W-1:0] ep_nums,
  input  wire logic [uec_pkg::EPN_W-1:0]     tok_ep,
  output logic                               hit,
  output logic [uec_pkg::IDX_W-1:0]          idx
);
  logic [NUM-1:0] eq; // Per-register compare

  // One comparator per endpoint register
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_cmp
      assign eq[g] = (ep_nums[g*uec_pkg::EPN_W +: uec_pkg::EPN_W] == tok_ep);
    end
  endgenerate

  // Lowest matching register wins
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (eq[i]) begin
        hit = 1'b1;
        idx = uec_pkg::IDX_W'(i);
      end
    end
  end
endmodule : uec_ep_match
`default_nettype wire

// ===== hw/uec_ep_reg.sv
/*
  One endpoint control and status register with its access classes.
  Assumes write strobes and hardware events are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module uec_ep_reg (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic                     wr_en,
  input  wire logic [uec_pkg::REG_W-1:0] wdata,
  input  wire uec_pkg::uec_evt_s        evt,
  output logic [uec_pkg::REG_W-1:0]     value
);
  logic [uec_pkg::REG_W-1:0] val_r;   // Register contents
  logic [uec_pkg::REG_W-1:0] val_nxt; // Next contents
  logic [uec_pkg::REG_W-1:0] tog_w;   // Software inversions
  logic [uec_pkg::REG_W-1:0] keep_w;  // Software keep mask

  // Software part of the update
  always_comb begin
    tog_w  = wr_en ? (wdata & uec_pkg::TOG_MASK) : '0;
    keep_w = wr_en ? (wdata | ~uec_pkg::W0C_MASK) : '1;
    val_nxt = (val_r & keep_w) ^ tog_w;
    if (wr_en) begin
      // Plain fields take the written value
      val_nxt = (val_nxt & ~uec_pkg::RW_MASK) | (wdata & uec_pkg::RW_MASK);
    end
    // Hardware flips combine with software inversions
    val_nxt[uec_pkg::RX_TOG_B] = val_nxt[uec_pkg::RX_TOG_B] ^ evt.rx_flip;
    val_nxt[uec_pkg::TX_TOG_B] = val_nxt[uec_pkg::TX_TOG_B] ^ evt.tx_flip;
    // Completion sets win over a clear in the same cycle
    if (evt.rx_done) begin
      val_nxt[uec_pkg::RX_DONE_B] = 1'b1;
      val_nxt[uec_pkg::SETUP_B]   = evt.setup;
    end
    if (evt.tx_done) begin
      val_nxt[uec_pkg::TX_DONE_B] = 1'b1;
    end
  end

  // Register update
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      val_r <= uec_pkg::EP_RESET;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign value = val_r;
endmodule : uec_ep_reg
`default_nettype wire

// ===== testbench/uec_checker.sv
/*
  Port-level assertions for the endpoint control and status block.
  Assumes it is bound to uec_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module uec_checker (
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 tok_valid,
  input wire uec_pkg::uec_token_s  tok,
  input wire logic                 xact_done,
  input wire logic                 ans_valid,
  input wire uec_pkg::uec_answer_s ans,
  input wire logic                 busy
);
  // One clock domain, one reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read");
  a_rdata_upper: assert property (reg_rvalid |-> reg_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_token_answer: assert property (tok_valid && !busy |=> ans_valid)
    else $error("token not answered next cycle");
  a_busy_refuse: assert property (tok_valid && busy |=> !ans_valid)
    else $error("token answered while busy");
  a_busy_open: assert property (ans_valid && ans.reply inside {uec_pkg::REPLY_ACCEPT, uec_pkg::REPLY_SEND}
    |-> busy)
    else $error("accepted transfer did not open");
  a_busy_rise: assert property ($rose(busy) |-> ans_valid)
    else $error("busy rose without an answer");
  a_busy_close: assert property (busy && xact_done |=> !busy)
    else $error("transaction end did not close");
  a_reply_dir: assert property (ans_valid |-> (($past(tok.kind) == uec_pkg::TOK_IN) ?
    ans.reply != uec_pkg::REPLY_ACCEPT : ans.reply != uec_pkg::REPLY_SEND))
    else $error("reply does not suit token direction");
  a_answer_hold: assert property (!ans_valid |-> $stable(ans))
    else $error("answer changed between answers");
endmodule : uec_checker
bind uec_top uec_checker uec_checker_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tok_valid(tok_valid), .tok(tok),
  .xact_done(xact_done), .ans_valid(ans_valid), .ans(ans), .busy(busy));
`default_nettype wire

// ===== testbench/uec_engine_model.sv
/*
  Behavioural serial engine: presents tokens, collects the answer and
  closes accepted transfers after a chosen gap. Driven by task calls.
*/
`timescale 1ns/1ps
`default_nettype none
module uec_engine_model (
  input wire logic                  clk_sys,
  input wire logic                  ans_valid,
  input wire uec_pkg::uec_answer_s  ans,
  output logic                      tok_valid,
  output uec_pkg::uec_token_s       tok,
  output logic                      xact_done,
  output logic                      xact_ok
);
  // Idle lines at time zero
  initial begin
    tok_valid = 1'b0;
    tok = '0;
    xact_done = 1'b0;
    xact_ok = 1'b0;
  end
  // One token, its answer, and the closing pulse when accepted
  task automatic transact(input uec_pkg::uec_tok_e k, input logic [3:0] ep, input logic nz,
                          input logic ok, input int gap, output uec_pkg::uec_answer_s a, output logic seen);
    @(posedge clk_sys);
    #1;
    tok_valid = 1'b1;
    tok = '{k, ep, nz};
    @(posedge clk_sys);
    #1;
    tok_valid = 1'b0;
    tok = uec_pkg::uec_token_s'(~tok); // Released lines do not hold
    seen = ans_valid;
    a = ans;
    if (seen && a.reply inside {uec_pkg::REPLY_ACCEPT, uec_pkg::REPLY_SEND}) begin
      repeat (gap) @(posedge clk_sys);
      #1;
      xact_done = 1'b1;
      xact_ok = ok;
      @(posedge clk_sys);
      #1;
      xact_done = 1'b0;
      xact_ok = ~ok;
    end
  endtask : transact
endmodule : uec_engine_model
`default_nettype wire

// ===== testbench/uec_top_test.sv
/*
  Self-checking bench for uec_top: register access, token replies,
  completion bookkeeping and double buffering. Needs the engine model.
*/
`timescale 1ns/1ps
`default_nettype none
module uec_top_test;
  logic clk_sys, resetn, reg_wr, reg_rd, reg_rvalid, tok_valid, xact_done, xact_ok, ans_valid, busy;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  uec_pkg::uec_token_s  tok;
  uec_pkg::uec_answer_s ans;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  uec_top #(.NUM_EP(8)) uec_top_inst (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .tok_valid(tok_valid), .tok(tok), .xact_done(xact_done), .xact_ok(xact_ok), .ans_valid(ans_valid),
    .ans(ans), .busy(busy));
  uec_engine_model uec_engine_model_inst (.clk_sys(clk_sys), .ans_valid(ans_valid), .ans(ans),
    .tok_valid(tok_valid), .tok(tok), .xact_done(xact_done), .xact_ok(xact_ok));
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Register write; upper half carries junk that must be ignored
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = {16'hffff, d};
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, {16'h0, exp});
  endtask : rd
  // Token through the engine model; buf_sel judged only when double-buffered
  task automatic tx(input uec_pkg::uec_tok_e k, input logic [3:0] ep, input logic nz, input logic ok,
                    input int gap, input uec_pkg::uec_answer_s e, input logic full);
    uec_pkg::uec_answer_s a;
    logic seen;
    uec_engine_model_inst.transact(k, ep, nz, ok, gap, a, seen);
    chk({31'h0, seen}, 32'h1);
    chk({29'h0, a.reply}, {29'h0, e.reply});
    if (full) chk({26'h0, a.toggle, a.dbl_buf, a.buf_sel & a.dbl_buf, a.ep_idx},
                  {26'h0, e.toggle, e.dbl_buf, e.buf_sel, e.ep_idx});
  endtask : tx
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 16'h0000);
    rd(8'h40, 16'h0000);
  endtask : t_reset
  task automatic t_access();
    wr(8'h1c, 16'hffff);
    rd(8'h1c, 16'h777f);
    wr(8'h1c, 16'h7077);
    rd(8'h1c, 16'h0007);
  endtask : t_access
  task automatic t_setup();
    wr(8'h00, 16'h3300); // Endpoint zero as control, never bulk with extend
    tx(uec_pkg::TOK_SETUP, 4'h0, 1'b1, 1'b1, 1, '{uec_pkg::REPLY_STALL, 1'b0, 1'b0, 1'b0, 3'h0}, 1'b1);
    tx(uec_pkg::TOK_SETUP, 4'h0, 1'b0, 1'b1, 5, '{uec_pkg::REPLY_ACCEPT, 1'b0, 1'b0, 1'b0, 3'h0}, 1'b1);
    rd(8'h00, 16'hfb00);
    wr(8'h00, 16'h8b00);
    rd(8'h00, 16'hfb00);
    wr(8'h00, 16'h0300);
    rd(8'h00, 16'h7b00);
  endtask : t_setup
  task automatic t_states();
    uec_pkg::uec_reply_e ro [4] = '{uec_pkg::REPLY_IGNORE, uec_pkg::REPLY_STALL, uec_pkg::REPLY_NAK,
                                    uec_pkg::REPLY_ACCEPT};
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, 16'h0603 | 16'(s << 12) | 16'(s << 4));
      tx(uec_pkg::TOK_OUT, 4'h3, 1'b0, 1'b0, 1, '{ro[s], 1'b0, 1'b0, 1'b0, 3'h3}, 1'b1);
      tx(uec_pkg::TOK_IN, 4'h3, 1'b0, s == 3, 2,
         '{(s == 3) ? uec_pkg::REPLY_SEND : ro[s], 1'b0, 1'b0, 1'b0, 3'h3}, 1'b1);
      if (s < 3) wr(8'h0c, 16'h0603 | 16'(s << 12) | 16'(s << 4));
    end
    rd(8'h0c, 16'h36f3);
  endtask : t_states
  task automatic t_double();
    wr(8'h14, 16'h3025);
    for (int k = 3; k >= 0; k--) begin
      wr(8'h14, 16'h0105 | 16'(k << 9));
      tx(uec_pkg::TOK_IN, 4'h5, 1'b0, 1'b0, 1,
         '{uec_pkg::REPLY_NAK, 1'b0, k == 0, k == 0, 3'h5}, 1'b1);
    end
    wr(8'h14, 16'h0115);
    tx(uec_pkg::TOK_IN, 4'h5, 1'b0, 1'b1, 5, '{uec_pkg::REPLY_SEND, 1'b0, 1'b1, 1'b1, 3'h5}, 1'b1);
    tx(uec_pkg::TOK_OUT, 4'h5, 1'b0, 1'b1, 1, '{uec_pkg::REPLY_ACCEPT, 1'b0, 1'b1, 1'b0, 3'h5}, 1'b1);
    tx(uec_pkg::TOK_IN, 4'h5, 1'b0, 1'b0, 1, '{uec_pkg::REPLY_SEND, 1'b1, 1'b1, 1'b0, 3'h5}, 1'b1);
    rd(8'h14, 16'hf1f5);
  endtask : t_double
  task automatic t_route();
    tx(uec_pkg::TOK_OUT, 4'hd, 1'b0, 1'b0, 1, '{uec_pkg::REPLY_IGNORE, 1'b0, 1'b0, 1'b0, 3'h0}, 1'b0);
    tx(uec_pkg::TOK_IN, 4'h7, 1'b0, 1'b0, 1, '{uec_pkg::REPLY_IGNORE, 1'b0, 1'b0, 1'b0, 3'h7}, 1'b1);
  endtask : t_route
  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (5) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_reset();
    t_access();
    t_setup();
    t_states();
    t_double();
    t_route();
    tally_and_finish();
  end
endmodule : uec_top_test
`default_nettype wire
